// >>> core/pdc_dma_channel.sv
// Reader and writer DMA channels with APB registers and an AHB master port
// Overview of operation
// R1 - Channels reach data RAM as an AHB master through the interconnect.
// R2 - Addresses outside the RAM window are refused; flash is never accessed.
// R3 - Independent reader and writer channels, each with pointer and count.
// R4 - On start the reader fetches bytes from its pointer up to max count.
// R5 - Max byte count ends the buffer; never more bytes than that count.
// R6 - Amount register holds bytes actually moved, possibly below max count.
// R7 - Software keeps max byte count within the real buffer size.
// R8 - Software loads a valid RAM pointer before starting a channel.
// R9 - Bad pointers may fault or corrupt RAM; no further guard needed.
// R10 - Under congestion the channel stalls, or in drop mode loses bytes.
// R11 - Linear list mode exists only on the reader, which has the setting.
// R12 - List mode advances the pointer by max count per finished item.
// R13 - Processor and channels are masters; RAM and peripherals are slaves.
// R14 - Interconnect grants by fixed priority; reader outranks writer here.
// R15 - Byte-aligned pointers; byte-sized accesses leave neighbours intact.
// R16 - Amount updates at transfer end and an end pulse goes out.
`timescale 1ns/100ps
module pdc_dma_channel #(
    parameter int          CW       = 16,
    parameter logic [31:0] RAM_BASE = 32'h2000_0000,
    parameter logic [31:0] RAM_SIZE = 32'h0004_0000
) (
    input  wire logic        ref_clk_in,
    input  wire logic        rst_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic [31:0]      prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    output logic             hbusreq_out,
    input  wire logic        hgrant_in,
    output logic [1:0]       htrans_out,
    output logic [31:0]      haddr_out,
    output logic             hwrite_out,
    output logic [2:0]       hsize_out,
    output logic [31:0]      hwdata_out,
    input  wire logic [31:0] hrdata_in,
    input  wire logic        hready_in,
    output logic [7:0]       rd_data_out,
    output logic             rd_valid_out,
    input  wire logic        rd_ready_in,
    input  wire logic [7:0]  wr_data_in,
    input  wire logic        wr_valid_in,
    input  wire logic        wr_last_in,
    output logic             wr_ready_out,
    output logic             rd_end_out,
    output logic             wr_end_out,
    output logic             irq_out
);
    // Counts wider than the data bus cannot be loaded in one write
    if (CW < 1 || CW > 32)
    begin : g_cw_check
        $error("CW out of range");
    end
    ////////////////////////////////////////////////////////////////////////
    localparam int EV_W_L = pdc_pkg::EV_W;
    logic [31:0]   ptr_q [2];
    logic [31:0]   ptr_d [2];
    logic [CW-1:0] max_q [2];
    logic [CW-1:0] max_d [2];
    logic [CW-1:0] cnt_q [2];
    logic [CW-1:0] cnt_d [2];
    logic [CW-1:0] amt_q [2];
    logic [CW-1:0] amt_d [2];
    logic [1:0]    busy_q, busy_d, end_q, end_d, fin;
    logic          drop_q, drop_d, list_q, list_d, last_q, last_d;
    logic [EV_W_L-1:0] ev_q, ev_d, en_q, en_d;
    logic [31:0]   prd_q, prd_d, rdat;
    logic [7:0]    rb_q, rb_d, wb_q, wb_d;
    logic          rv_q, rv_d, wv_q, wv_d, ch_q, ch_d;
    logic          apb_wr, in_ram;
    logic [31:0]   lim;
    pdc_pkg::pdc_state_t st_q, st_d;

    assign apb_wr      = psel_in && penable_in && pwrite_in;
    assign pready_out  = 1'b1;
    assign prdata_out  = prd_q;
    assign irq_out     = |(ev_q & en_q);
    assign rd_end_out  = end_q[0];
    assign wr_end_out  = end_q[1];
    assign rd_data_out = rb_q;
    assign rd_valid_out = rv_q;
    // Drop mode keeps the peripheral flowing and loses bytes instead
    assign wr_ready_out = busy_q[1] && !last_q && cnt_q[1] != max_q[1]
                          && (drop_q || !wv_q); // R10
    ////////////////////////////////////////////////////////////////////////
    // APB decode and read mux
    always_comb
    begin
        pslverr_out = 1'b0;
        rdat        = 32'h0000_0000;
        case (paddr_in)
            pdc_pkg::CTRL_OFS:   rdat = {28'h0, list_q, drop_q, 2'h0};
            pdc_pkg::RD_PTR_OFS: rdat = ptr_q[0];
            pdc_pkg::RD_MAX_OFS: rdat = 32'(max_q[0]);
            pdc_pkg::RD_AMT_OFS: rdat = 32'(amt_q[0]); // R6
            pdc_pkg::WR_PTR_OFS: rdat = ptr_q[1];
            pdc_pkg::WR_MAX_OFS: rdat = 32'(max_q[1]);
            pdc_pkg::WR_AMT_OFS: rdat = 32'(amt_q[1]); // R6
            pdc_pkg::STAT_OFS:   rdat = {30'h0, busy_q};
            pdc_pkg::EV_OFS:     rdat = 32'(ev_q);
            pdc_pkg::EV_CLR_OFS: rdat = 32'h0000_0000;
            pdc_pkg::EV_EN_OFS:  rdat = 32'(en_q);
            default:             pslverr_out = psel_in && penable_in;
        endcase
        prd_d = (psel_in && !penable_in) ? rdat : prd_q;
    end
    ////////////////////////////////////////////////////////////////////////
    // Channel state, registers and events
    always_comb
    begin
        ptr_d  = ptr_q;
        max_d  = max_q;
        cnt_d  = cnt_q;
        amt_d  = amt_q;
        busy_d = busy_q;
        end_d  = 2'b00;
        drop_d = drop_q;
        list_d = list_q;
        last_d = last_q;
        en_d   = en_q;
        ev_d   = ev_q;
        rb_d   = rb_q;
        rv_d   = rv_q && !rd_ready_in;
        wb_d   = wb_q;
        wv_d   = wv_q;
        st_d   = st_q;
        ch_d   = ch_q;
        lim    = RAM_BASE + RAM_SIZE;
        in_ram = 1'b0;
        fin[0] = busy_q[0] && cnt_q[0] == max_q[0] && !rv_q
                 && st_q == pdc_pkg::ST_IDLE; // R5
        fin[1] = busy_q[1] && !wv_q && st_q == pdc_pkg::ST_IDLE
                 && (cnt_q[1] == max_q[1] || last_q); // R5
        // Byte from the peripheral into the writer holding stage
        if (wr_valid_in && wr_ready_out)
        begin
            if (wv_q)
                ev_d[pdc_pkg::EV_DROP] = 1'b1; // R10
            else
            begin
                wb_d   = wr_data_in;
                wv_d   = 1'b1;
                last_d = wr_last_in;
            end
        end
        // Bus master sequencing; requests go one byte at a time
        case (st_q)
            pdc_pkg::ST_IDLE:
            begin
                if (busy_q[0] && !rv_q && cnt_q[0] != max_q[0])
                begin
                    ch_d = 1'b0; // R14
                    st_d = pdc_pkg::ST_ADDR;
                end
                else if (busy_q[1] && wv_q)
                begin
                    ch_d = 1'b1;
                    st_d = pdc_pkg::ST_ADDR;
                end
            end
            pdc_pkg::ST_ADDR:
                if (hgrant_in && hready_in)
                    st_d = pdc_pkg::ST_DATA; // R10
            pdc_pkg::ST_DATA:
                if (hready_in)
                begin
                    st_d = pdc_pkg::ST_IDLE;
                    cnt_d[ch_q] = cnt_q[ch_q] + 1'b1;
                    if (!ch_q)
                    begin
                        rb_d = hrdata_in[8*haddr_out[1:0] +: 8]; // R15
                        rv_d = 1'b1;
                    end
                    else
                        wv_d = 1'b0;
                end
            default: st_d = pdc_pkg::ST_IDLE;
        endcase
        // End of buffer: publish amount, raise events
        for (int c = 0; c < 2; c++)
        begin
            if (fin[c])
            begin
                amt_d[c]  = cnt_q[c]; // R16
                busy_d[c] = 1'b0;
                end_d[c]  = 1'b1; // R16
                ev_d[c]   = 1'b1;
            end
        end
        if (fin[1])
            last_d = 1'b0;
        if (fin[0] && list_q)
            ptr_d[0] = ptr_q[0] + 32'(max_q[0]); // R12
        // Software writes; a hardware event set wins over a clear unless that event bit was already set
        if (apb_wr)
        begin
            case (paddr_in)
                pdc_pkg::CTRL_OFS:
                begin
                    drop_d = pwdata_in[pdc_pkg::CTRL_DROP];
                    list_d = pwdata_in[pdc_pkg::CTRL_LIST]; // R11
                    for (int c = 0; c < 2; c++)
                    begin
                        in_ram = ptr_q[c] >= RAM_BASE
                                 && ptr_q[c] + 32'(max_q[c]) <= lim; // R2
                        if (pwdata_in[c] && !busy_q[c])
                        begin
                            if (in_ram)
                            begin
                                busy_d[c] = 1'b1; // R4
                                cnt_d[c]  = '0;
                            end
                            else
                                ev_d[pdc_pkg::EV_RANGE] = 1'b1; // R2
                        end
                    end
                end
                pdc_pkg::RD_PTR_OFS: ptr_d[0] = pwdata_in; // R3
                pdc_pkg::RD_MAX_OFS: max_d[0] = pwdata_in[CW-1:0];
                pdc_pkg::WR_PTR_OFS: ptr_d[1] = pwdata_in; // R3
                pdc_pkg::WR_MAX_OFS: max_d[1] = pwdata_in[CW-1:0];
                pdc_pkg::EV_CLR_OFS: ev_d = ev_d & ~(ev_q & pwdata_in[EV_W_L-1:0]
                                            & ~(ev_d ^ ev_q));
                pdc_pkg::EV_EN_OFS:  en_d = pwdata_in[EV_W_L-1:0];
                default: ;
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // AHB address and data phase drive
    always_comb
    begin
        hbusreq_out = st_q == pdc_pkg::ST_ADDR; // R1 R13
        htrans_out  = hbusreq_out ? pdc_pkg::HTRANS_NSEQ : pdc_pkg::HTRANS_IDLE;
        haddr_out   = ptr_q[ch_q] + 32'(cnt_q[ch_q]); // R9
        hwrite_out  = ch_q;
        hsize_out   = pdc_pkg::HSIZE_BYTE; // R15
        hwdata_out  = {4{wb_q}};
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            for (int c = 0; c < 2; c++)
            begin
                ptr_q[c] <= pdc_pkg::PTR_RST;
                max_q[c] <= '0;
                cnt_q[c] <= '0;
                amt_q[c] <= '0;
            end
            busy_q <= 2'h0;
            end_q  <= 2'h0;
            drop_q <= 1'b0;
            list_q <= 1'b0;
            last_q <= 1'b0;
            ev_q   <= pdc_pkg::EV_RST;
            en_q   <= pdc_pkg::EV_RST;
            prd_q  <= 32'h0000_0000;
            rb_q   <= 8'h00;
            rv_q   <= 1'b0;
            wb_q   <= 8'h00;
            wv_q   <= 1'b0;
            ch_q   <= 1'b0;
            st_q   <= pdc_pkg::ST_IDLE;
        end
        else
        begin
            ptr_q  <= ptr_d;
            max_q  <= max_d;
            cnt_q  <= cnt_d;
            amt_q  <= amt_d;
            busy_q <= busy_d;
            end_q  <= end_d;
            drop_q <= drop_d;
            list_q <= list_d;
            last_q <= last_d;
            ev_q   <= ev_d;
            en_q   <= en_d;
            prd_q  <= prd_d;
            rb_q   <= rb_d;
            rv_q   <= rv_d;
            wb_q   <= wb_d;
            wv_q   <= wv_d;
            ch_q   <= ch_d;
            st_q   <= st_d;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    a_ram_window_only: assert property ( // R2
        htrans_out == pdc_pkg::HTRANS_NSEQ |-> haddr_out >= RAM_BASE
        && haddr_out < RAM_BASE + RAM_SIZE)
        else $error("access outside RAM window");
    a_byte_size: assert property ( // R15
        htrans_out != pdc_pkg::HTRANS_IDLE |-> hsize_out == pdc_pkg::HSIZE_BYTE)
        else $error("access not byte sized");
    a_count_bound: assert property ( // R5
        busy_q[0] |-> cnt_q[0] <= max_q[0])
        else $error("reader past max count");
    a_amount_latch: assert property ( // R6
        rd_end_out |-> amt_q[0] == $past(cnt_q[0]))
        else $error("amount not taken at end");
    a_end_event: assert property ( // R16
        wr_end_out |-> ev_q[pdc_pkg::EV_WR_END] && !busy_q[1])
        else $error("writer end without event");
    a_stall_hold: assert property ( // R10
        hbusreq_out && !hgrant_in |=> hbusreq_out && $stable(haddr_out))
        else $error("request dropped while stalled");
    a_list_step: assert property ( // R12
        rd_end_out && list_q |-> ptr_q[0] == $past(ptr_q[0]) + 32'($past(max_q[0])))
        else $error("list pointer not advanced");
    a_first_fetch: assert property ( // R4
        $rose(busy_q[0]) |=> ##[0:3] hbusreq_out && haddr_out == ptr_q[0]
        || max_q[0] == '0)
        else $error("reader did not start at pointer");
endmodule : pdc_dma_channel

// >>> core/pdc_pkg.sv
// Shared constants for the peripheral DMA channel
package pdc_pkg;
    localparam logic [7:0]  CTRL_OFS    = 8'h00;
    localparam logic [7:0]  RD_PTR_OFS  = 8'h04;
    localparam logic [7:0]  RD_MAX_OFS  = 8'h08;
    localparam logic [7:0]  RD_AMT_OFS  = 8'h0c;
    localparam logic [7:0]  WR_PTR_OFS  = 8'h10;
    localparam logic [7:0]  WR_MAX_OFS  = 8'h14;
    localparam logic [7:0]  WR_AMT_OFS  = 8'h18;
    localparam logic [7:0]  STAT_OFS    = 8'h1c;
    localparam logic [7:0]  EV_OFS      = 8'h20;
    localparam logic [7:0]  EV_CLR_OFS  = 8'h24;
    localparam logic [7:0]  EV_EN_OFS   = 8'h28;
    // Control fields
    localparam int          CTRL_RD_GO  = 0;
    localparam int          CTRL_WR_GO  = 1;
    localparam int          CTRL_DROP   = 2;
    localparam int          CTRL_LIST   = 3;
    // Event bits
    localparam int          EV_RD_END   = 0;
    localparam int          EV_WR_END   = 1;
    localparam int          EV_DROP     = 2;
    localparam int          EV_RANGE    = 3;
    localparam int          EV_W        = 4;
    localparam logic [31:0] PTR_RST     = 32'h0000_0000;
    localparam logic [EV_W-1:0] EV_RST  = 4'h0;
    // AHB codes
    localparam logic [1:0]  HTRANS_IDLE = 2'h0;
    localparam logic [1:0]  HTRANS_NSEQ = 2'h2;
    localparam logic [2:0]  HSIZE_BYTE  = 3'h0;
    typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DATA} pdc_state_t;
endpackage : pdc_pkg

// >>> test/pdc_ram_model.sv
// AHB data RAM stand-in with grant and wait-state stalls
`timescale 1ns/100ps
module pdc_ram_model (
    input  wire logic        ref_clk_in,
    input  wire logic        rst_in,
    input  wire logic        slow_in,
    input  wire logic        hbusreq_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic        hwrite_in,
    input  wire logic [31:0] hwdata_in,
    output logic             hgrant_out,
    output logic [31:0]      hrdata_out,
    output logic             hready_out
);
    logic [7:0]  mem [256];
    logic        ph_q;
    logic        wr_q;
    logic [31:0] adr_q;
    logic [31:0] noise_q;
    logic [4:0]  sh;
    assign sh = {adr_q[1:0], 3'h0};
    // Unused lanes carry noise so a wrong lane pick shows up
    assign hrdata_out = (ph_q && !wr_q) ?
        ((noise_q & ~(32'hff << sh)) | (32'(mem[adr_q[7:0]]) << sh)) : noise_q;
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge ref_clk_in)
    begin
        noise_q <= $urandom;
        // Other masters may own the slave: grant withheld at random
        hgrant_out <= !slow_in || $urandom_range(0, 1) == 1;
        hready_out <= !slow_in || $urandom_range(0, 1) == 1;
        if (rst_in)
            ph_q <= 1'b0;
        else if (hready_out)
        begin
            if (ph_q && wr_q)
                mem[adr_q[7:0]] <= hwdata_in[sh +: 8];
            ph_q  <= hbusreq_in && hgrant_out && htrans_in == pdc_pkg::HTRANS_NSEQ;
            adr_q <= haddr_in;
            wr_q  <= hwrite_in;
        end
    end
endmodule : pdc_ram_model

// >>> test/testbench.sv
// Self-checking bench for the peripheral DMA channel
`timescale 1ns/100ps
module testbench;
    localparam logic [31:0] BASE = 32'h2000_0000;
    logic ref_clk_in = 1'b0, rst_in = 1'b1, slow = 1'b0;
    logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0, pready_out, pslverr_out;
    logic [7:0] paddr_in = 8'h0, rd_data_out, wr_data_in = 8'h0;
    logic [31:0] pwdata_in = 32'h0, prdata_out, haddr_out, hwdata_out, hrdata_in;
    logic hbusreq_out, hgrant_in, hwrite_out, hready_in, rd_valid_out, rd_ready_in = 1'b0;
    logic wr_valid_in = 1'b0, wr_last_in = 1'b0, wr_ready_out, rd_end_out, wr_end_out, irq_out;
    logic [1:0] htrans_out;
    logic [2:0] hsize_out;
    logic [32:0] apb_q [$];
    logic [7:0] rd_q [$];
    logic [7:0] pre [256];
    logic [7:0] wbuf [8];
    int miscompares = 0, tests_run = 0, i, j, n;
    always #2.5 ref_clk_in = ~ref_clk_in;
    pdc_dma_channel #(.RAM_BASE(BASE)) u_dut (.ref_clk_in, .rst_in, .psel_in, .penable_in,
        .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .hbusreq_out,
        .hgrant_in, .htrans_out, .haddr_out, .hwrite_out, .hsize_out, .hwdata_out, .hrdata_in,
        .hready_in, .rd_data_out, .rd_valid_out, .rd_ready_in, .wr_data_in, .wr_valid_in,
        .wr_last_in, .wr_ready_out, .rd_end_out, .wr_end_out, .irq_out);
    pdc_ram_model u_ram (.ref_clk_in, .rst_in, .slow_in(slow), .hbusreq_in(hbusreq_out),
        .htrans_in(htrans_out), .haddr_in(haddr_out), .hwrite_in(hwrite_out),
        .hwdata_in(hwdata_out), .hgrant_out(hgrant_in), .hrdata_out(hrdata_in),
        .hready_out(hready_in));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic stop_test;
        $display("Comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : stop_test
    task automatic guard(input int k, input int lim);
        if (k == lim)
        begin
            miscompares++;
            $display("Error wait expected answer seen timeout");
            stop_test();
        end
    endtask : guard
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge ref_clk_in);
        penable_in <= 1'b1;
        for (k = 0; k < 50; k++)
        begin
            @(posedge ref_clk_in);
            if (pready_out === 1'b1) break;
        end
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        guard(k, 50);
        @(posedge ref_clk_in);
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        apb_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask : rd
    task automatic wait_end(input logic wr);
        int k;
        for (k = 0; k < 3000; k++)
        begin
            @(posedge ref_clk_in);
            if ((wr ? wr_end_out : rd_end_out) === 1'b1) break;
        end
        guard(k, 3000);
    endtask : wait_end
    task automatic put(input logic [7:0] b, input logic last);
        int k;
        wr_valid_in <= 1'b1;
        wr_data_in <= b;
        wr_last_in <= last;
        for (k = 0; k < 300; k++)
        begin
            @(posedge ref_clk_in);
            if (wr_ready_out === 1'b1) break;
        end
        wr_valid_in <= 1'b0;
        wr_last_in <= 1'b0;
        guard(k, 300);
        @(posedge ref_clk_in);
    endtask : put
    ////////////////////////////////////////////////////////////////////////////////
    // Watcher: every read answer and handed-off byte is matched to the oldest note
    always @(posedge ref_clk_in)
    begin
        if ((psel_in & penable_in & pready_out & !pwrite_in) === 1'b1)
            check("read data", {pslverr_out, prdata_out}, apb_q.pop_front());
        if ((rd_valid_out & rd_ready_in) === 1'b1)
            check("reader byte", {25'h0, rd_data_out}, {25'h0, rd_q.pop_front()});
        rd_ready_in <= $urandom_range(0, 1) == 1;
    end
    initial
    begin
        void'($urandom(32'hed72b019));
        for (i = 0; i < 256; i++)
        begin
            pre[i] = 8'($urandom);
            u_ram.mem[i] = pre[i];
        end
        repeat (6) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        @(posedge ref_clk_in);
        rd(pdc_pkg::RD_PTR_OFS, {1'b0, pdc_pkg::PTR_RST});
        rd(8'h2c, 33'h1_0000_0000);
        apb(1'b1, pdc_pkg::EV_EN_OFS, 32'hf);
        // Reader from an odd address on a congested bus
        slow <= 1'b1;
        apb(1'b1, pdc_pkg::RD_PTR_OFS, BASE + 32'h1);
        apb(1'b1, pdc_pkg::RD_MAX_OFS, 32'h5);
        for (i = 1; i < 6; i++) rd_q.push_back(pre[i]);
        apb(1'b1, pdc_pkg::CTRL_OFS, 32'h1 << pdc_pkg::CTRL_RD_GO);
        wait_end(1'b0);
        rd(pdc_pkg::RD_AMT_OFS, 33'h5);
        rd(pdc_pkg::EV_OFS, 33'h1 << pdc_pkg::EV_RD_END);
        check("irq set", {32'h0, irq_out}, 33'h1);
        apb(1'b1, pdc_pkg::EV_CLR_OFS, 32'hf);
        check("irq clear", {32'h0, irq_out}, 33'h0);
        // Linear list: two items taken back to back from consecutive RAM
        slow <= 1'b0;
        apb(1'b1, pdc_pkg::RD_PTR_OFS, BASE + 32'h10);
        apb(1'b1, pdc_pkg::RD_MAX_OFS, 32'h4);
        for (i = 16; i < 24; i++) rd_q.push_back(pre[i]);
        for (j = 0; j < 2; j++)
        begin
            apb(1'b1, pdc_pkg::CTRL_OFS,
                (32'h1 << pdc_pkg::CTRL_RD_GO) | (32'h1 << pdc_pkg::CTRL_LIST));
            wait_end(1'b0);
            rd(pdc_pkg::RD_PTR_OFS, {1'b0, BASE + 32'h14 + 32'(4 * j)});
        end
        // Writer: short buffer ended by last, then a full buffer ended by count
        slow <= 1'b1;
        for (j = 0; j < 2; j++)
        begin
            n = j ? 4 : 3;
            apb(1'b1, pdc_pkg::WR_PTR_OFS, BASE + 32'(40 + 8 * j));
            apb(1'b1, pdc_pkg::WR_MAX_OFS, j ? 32'h4 : 32'h6);
            apb(1'b1, pdc_pkg::CTRL_OFS, 32'h1 << pdc_pkg::CTRL_WR_GO);
            for (i = 0; i < n; i++)
            begin
                wbuf[i] = 8'($urandom);
                put(wbuf[i], j == 0 && i == n - 1);
            end
            wait_end(1'b1);
            rd(pdc_pkg::WR_AMT_OFS, 33'(n));
            for (i = 0; i < n; i++)
                check("ram byte", 33'(u_ram.mem[40 + 8 * j + i]), 33'(wbuf[i]));
            check("neighbour", 33'(u_ram.mem[40 + 8 * j + n]), 33'(pre[40 + 8 * j + n]));
            check("neighbour", 33'(u_ram.mem[39 + 8 * j]), 33'(pre[39 + 8 * j]));
        end
        // Drop mode on a free bus: the second byte meets a held byte and is lost
        slow <= 1'b0;
        apb(1'b1, pdc_pkg::EV_CLR_OFS, 32'hf);
        apb(1'b1, pdc_pkg::WR_PTR_OFS, BASE + 32'h40);
        apb(1'b1, pdc_pkg::CTRL_OFS,
            (32'h1 << pdc_pkg::CTRL_WR_GO) | (32'h1 << pdc_pkg::CTRL_DROP));
        for (i = 0; i < 3; i++)
        begin
            wbuf[i] = 8'($urandom);
            put(wbuf[i], i == 2);
        end
        wait_end(1'b1);
        rd(pdc_pkg::WR_AMT_OFS, 33'h2);
        rd(pdc_pkg::EV_OFS, (33'h1 << pdc_pkg::EV_DROP) | (33'h1 << pdc_pkg::EV_WR_END));
        check("drop kept", 33'(u_ram.mem[8'h40]), 33'(wbuf[0]));
        check("drop kept", 33'(u_ram.mem[8'h41]), 33'(wbuf[2]));
        check("drop neighbour", 33'(u_ram.mem[8'h42]), 33'(pre[8'h42]));
        // Pointer below the RAM window is refused
        apb(1'b1, pdc_pkg::EV_CLR_OFS, 32'hf);
        apb(1'b1, pdc_pkg::RD_PTR_OFS, BASE - 32'h1);
        apb(1'b1, pdc_pkg::CTRL_OFS, 32'h1 << pdc_pkg::CTRL_RD_GO);
        rd(pdc_pkg::EV_OFS, 33'h1 << pdc_pkg::EV_RANGE);
        rd(pdc_pkg::STAT_OFS, 33'h0);
        check("bytes left", 33'(rd_q.size()), 33'h0);
        stop_test();
    end
endmodule : testbench
